// ===== src/pph_top.sv
// discrete handshake logic between a host sequencer and the motion core
// assumes pins arrive asynchronously, motion core signals on i_sys_clk
// Functional notes
// R1: contact-b lines are high when healthy
// R2: alarm output low while any alarm present
// R3: reset rise clears alarms; overcurrent stays
// R4: zone output high inside configured range
// R5: home-complete held after first homing, survives stop
// R6: home first when home-complete clear
// R7: absolute variant: home from backup, alarm voids
// R8: position-complete: ready high, start low, done high
// R9: codes drop with position-complete same cycle
// R10: codes low during stop or teaching
// R11: on ready, code only if within band
// R12: after push move, codes stay low; code set at completion, kept low only on return from stop or teaching
// R13: battery alarm low on low battery
// R14: battery error after long alarm interval
// R15: incremental variant: battery output held low
// R16: moving high exactly while actuator moves
// R17: stop status low during emergency stop
// R18: host holds pause high; low halts motion
// R19: servo energised exactly while servo-on high
// R20: reset during pause drops remaining travel; done only during a move, not during homing
// R21: 4-bit select picks entry 0 to 15
// R22: empty entry: no move, empty alarm
// R23: inputs double-synchronised, edges on synced copies
//
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module pph_top
  import pph_pkg::*;
#(
  parameter longint unsigned BATT_ERR_CYCLES = PPH_BATT_ERR_CYCLES
)(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_servo_on,
  input wire logic i_pause_n,
  input wire logic i_reset,
  input wire logic i_start,
  input wire logic [3:0] i_sel,
  input wire logic i_emg_n,
  input wire logic i_batt_low,
  input wire logic i_abs_variant,
  input wire logic i_abs_valid,
  input wire logic i_fault,
  input wire logic i_overcurrent,
  input wire logic i_home_done,
  input wire logic i_move_done,
  input wire logic i_mot_moving,
  input wire logic i_in_band,
  input wire logic [15:0] i_act_pos,
  input wire pph_axi_req_s i_axi,
  output var pph_axi_rsp_s o_axi,
  output logic o_servo_en,
  output logic o_halt,
  output logic o_discard,
  output logic o_move_req,
  output logic o_home_req,
  output logic [3:0] o_move_idx,
  output logic o_abs_rst,
  output logic o_alarm_n,
  output logic o_zone,
  output logic o_home_cpl,
  output logic o_pos_cpl,
  output logic [3:0] o_cpl_code,
  output logic o_batt_alm_n,
  output logic o_batt_err,
  output logic o_moving,
  output logic o_emg_n
);

  localparam logic [PPH_CNT_W-1:0] BATT_LIMIT = BATT_ERR_CYCLES;

  pph_state_s st, next_st;

  // byte-lane merge for axi writes
  function automatic logic [31:0] pph_merge(input logic [31:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        res[b*8 +: 8] = data[b*8 +: 8];
    end
    return res;
  endfunction : pph_merge

  // true when the address is word-aligned and inside the first 16 bytes
  function automatic logic pph_mapped(input logic [31:0] addr);
    return addr[31:4] == 28'h0000000 && addr[1:0] == 2'h0;
  endfunction : pph_mapped

  logic [31:0] rd_word;
  logic rise_start, rise_reset, emg_act, paused, alarm_any;
  logic [3:0] sel;

  // read mux; reserved bits read as zero
  always_comb
  begin
    unique case (i_axi.araddr[3:0])
      PPH_OFF_CTRL: rd_word = {31'h0, st.teach};
      PPH_OFF_ZONE: rd_word = {st.zone_hi, st.zone_lo};
      PPH_OFF_TABLE: rd_word = {st.push, st.entry_ok};
      default: rd_word = {16'h0, st.last_tgt, st.tgt, 1'b0, st.seq,
                          st.batt_err, st.abs_var, st.alm_oc,
                          st.alm_fault, st.alm_empty};
    endcase
  end

  // edges seen only on the second stage against the third
  assign rise_start = st.s2[PPH_PIN_START] & ~st.s3[PPH_PIN_START]; // R23
  assign rise_reset = st.s2[PPH_PIN_RESET] & ~st.s3[PPH_PIN_RESET]; // R23
  assign emg_act = ~st.s2[PPH_PIN_EMG_N]; // R1
  assign paused = ~st.s2[PPH_PIN_PAUSE_N]; // R1
  assign sel = st.s2[PPH_PIN_SEL_LO +: 4]; // R21
  assign alarm_any = st.alm_empty | st.alm_fault | st.alm_oc;

  // whole next-state computation
  always_comb
  begin
    next_st = st;
    next_st.move_req = 1'b0;
    next_st.home_req = 1'b0;
    next_st.discard = 1'b0;
    next_st.abs_rst = 1'b0;
    // two-stage synchroniser plus a history stage for edges
    next_st.s1 = {i_batt_low, i_emg_n, i_sel, i_start, i_reset,
                  i_pause_n, i_servo_on}; // R23
    next_st.s2 = st.s1; // R23
    next_st.s3 = st.s2;

    // strap caught once, after reset is released
    next_st.booted = 1'b1;
    if (!st.booted)
    begin
      next_st.abs_var = i_abs_variant;
      next_st.pos_cpl = 1'b1; // R8
      if (i_abs_variant && i_abs_valid)
        next_st.home_cpl = 1'b1; // R7
    end

    // reset edge clears first so a live cause sets again
    if (rise_reset)
    begin
      next_st.alm_empty = 1'b0; // R3
      next_st.alm_fault = 1'b0; // R3
    end
    if (i_fault)
      next_st.alm_fault = 1'b1; // R3
    if (i_overcurrent)
      next_st.alm_oc = 1'b1; // R3
    // alarm voids the absolute position; homing is not a fix
    if (st.abs_var && alarm_any)
      next_st.home_cpl = 1'b0; // R7

    // sequencer
    unique case (st.seq)
      PPH_IDLE:
      begin
        if (rise_start && !alarm_any && st.servo_en && !emg_act)
        begin
          if (!st.entry_ok[sel])
            next_st.alm_empty = 1'b1; // R22
          else
          begin
            next_st.pos_cpl = 1'b0; // R8
            next_st.code = 4'h0; // R9
            next_st.tgt = sel; // R21
            if (st.home_cpl)
            begin
              next_st.move_req = 1'b1;
              next_st.seq = PPH_MOVE;
            end
            else
            begin
              next_st.home_req = 1'b1; // R6
              next_st.seq = PPH_HOME;
            end
          end
        end
      end
      PPH_HOME:
      begin
        if (i_home_done)
        begin
          // absolute variant needs its own absolute reset instead
          if (!st.abs_var)
            next_st.home_cpl = 1'b1; // R5 R7
          next_st.move_req = 1'b1; // R6
          next_st.seq = PPH_MOVE;
        end
      end
      PPH_MOVE:
      begin
        if (i_move_done)
        begin
          next_st.pos_cpl = 1'b1; // R8
          next_st.code = st.tgt;
          next_st.last_tgt = st.tgt;
          next_st.last_push = st.push[st.tgt];
          next_st.seq = PPH_IDLE;
        end
        else if (rise_reset && paused)
        begin
          next_st.discard = 1'b1; // R20
          next_st.seq = PPH_IDLE;
        end
      end
    endcase

    // codes blocked by stop or teaching, re-judged on return
    if (emg_act || st.teach)
    begin
      next_st.code = 4'h0; // R10
      next_st.blocked = 1'b1;
    end
    else if (st.blocked)
    begin
      next_st.blocked = 1'b0;
      if (next_st.pos_cpl && i_in_band && !st.last_push) // R11 R12
        next_st.code = st.last_tgt;
      else
        next_st.code = 4'h0; // R12
    end

    // battery monitor; a long count, so it saturates
    if (st.abs_var && st.s2[PPH_PIN_BATT])
    begin
      if (st.batt_cnt >= BATT_LIMIT)
        next_st.batt_err = 1'b1; // R14
      else
        next_st.batt_cnt = st.batt_cnt + 64'h1; // R14
    end
    else
      next_st.batt_cnt = '0;
    next_st.batt_n = st.abs_var & ~st.s2[PPH_PIN_BATT]; // R13 R15

    // axi write address and data taken independently
    if (i_axi.awvalid && st.axi.awready)
    begin
      next_st.aw_ok = 1'b1;
      next_st.waddr = i_axi.awaddr[3:0];
      next_st.axi.bresp = pph_mapped(i_axi.awaddr) ?
                          PPH_RESP_OKAY : PPH_RESP_SLVERR;
    end
    if (i_axi.wvalid && st.axi.wready)
    begin
      next_st.w_ok = 1'b1;
      next_st.wdata = i_axi.wdata;
      next_st.wstrb = i_axi.wstrb;
    end
    if (st.axi.bvalid && i_axi.bready)
      next_st.axi.bvalid = 1'b0;
    if (st.aw_ok && st.w_ok && !st.axi.bvalid)
    begin
      next_st.aw_ok = 1'b0;
      next_st.w_ok = 1'b0;
      next_st.axi.bvalid = 1'b1;
      if (st.axi.bresp == PPH_RESP_OKAY)
      begin
        unique case (st.waddr)
          PPH_OFF_CTRL:
          begin
            if (st.wstrb[0])
            begin
              next_st.teach = st.wdata[PPH_CTRL_TEACH]; // R10
              if (st.wdata[PPH_CTRL_ABS_RST] && st.abs_var)
              begin
                next_st.abs_rst = 1'b1;
                next_st.home_cpl = 1'b1; // R7
              end
            end
          end
          PPH_OFF_ZONE:
            {next_st.zone_hi, next_st.zone_lo} =
              pph_merge({st.zone_hi, st.zone_lo}, st.wdata, st.wstrb);
          PPH_OFF_TABLE:
            {next_st.push, next_st.entry_ok} =
              pph_merge({st.push, st.entry_ok}, st.wdata, st.wstrb);
          default: next_st.wstrb = st.wstrb; // status is read-only
        endcase
      end
    end
    next_st.axi.awready = !next_st.aw_ok && !next_st.axi.bvalid;
    next_st.axi.wready = !next_st.w_ok && !next_st.axi.bvalid;

    // axi read, answered on the same edge that takes the address
    if (st.axi.rvalid && i_axi.rready)
      next_st.axi.rvalid = 1'b0;
    if (i_axi.arvalid && st.axi.arready)
    begin
      next_st.axi.rvalid = 1'b1;
      next_st.axi.rdata = pph_mapped(i_axi.araddr) ? rd_word : 32'h0;
      next_st.axi.rresp = pph_mapped(i_axi.araddr) ?
                          PPH_RESP_OKAY : PPH_RESP_SLVERR;
    end
    next_st.axi.arready = !next_st.axi.rvalid;

    // pin mirrors, zone compare and alarm output
    next_st.servo_en = st.s2[PPH_PIN_SERVO]; // R19
    next_st.halt = paused | emg_act; // R18
    next_st.moving = i_mot_moving; // R16
    next_st.emg_n = st.s2[PPH_PIN_EMG_N]; // R17
    next_st.zone = (i_act_pos >= st.zone_lo) &&
                   (i_act_pos <= st.zone_hi); // R4
    next_st.alarm_n = ~(next_st.alm_empty | next_st.alm_fault |
                        next_st.alm_oc); // R2
  end

  // single state register; enable freezes everything
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      st <= '0;
    else if (i_clk_en)
      st <= next_st;
  end

  assign o_axi = st.axi;
  assign o_servo_en = st.servo_en;
  assign o_halt = st.halt;
  assign o_discard = st.discard;
  assign o_move_req = st.move_req;
  assign o_home_req = st.home_req;
  assign o_move_idx = st.tgt;
  assign o_abs_rst = st.abs_rst;
  assign o_alarm_n = st.alarm_n;
  assign o_zone = st.zone;
  assign o_home_cpl = st.home_cpl;
  assign o_pos_cpl = st.pos_cpl;
  assign o_cpl_code = st.code;
  assign o_batt_alm_n = st.batt_n;
  assign o_batt_err = st.batt_err;
  assign o_moving = st.moving;
  assign o_emg_n = st.emg_n;

  // checks assume i_clk_en stays high
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n || !i_clk_en);

  a_alarm_tracks_flags: assert property ($past(i_rst_n) |-> // R2
    o_alarm_n == !(st.alm_empty | st.alm_fault | st.alm_oc))
    else $error("alarm output disagrees with alarm flags");
  a_reset_clears_empty: assert property ( // R3
    rise_reset && st.alm_empty |=> !st.alm_empty)
    else $error("reset edge did not clear empty alarm");
  a_overcurrent_stays: assert property (st.alm_oc |=> st.alm_oc) // R3
    else $error("overcurrent alarm cleared without power cycle");
  a_home_survives_stop: assert property ( // R5
    o_home_cpl && !st.abs_var && !o_emg_n |=> o_home_cpl)
    else $error("home complete dropped by emergency stop");
  a_start_drops_cpl: assert property ( // R8
    st.seq == PPH_IDLE && rise_start && !alarm_any && o_servo_en &&
    !emg_act && st.entry_ok[sel] |=> !o_pos_cpl && o_cpl_code == 4'h0)
    else $error("accepted start did not drop position complete");
  a_code_with_cpl: assert property ($fell(o_pos_cpl) |-> // R9
    o_cpl_code == 4'h0)
    else $error("code not zero when position complete fell");
  a_code_off_in_stop: assert property ( // R10
    emg_act |=> o_cpl_code == 4'h0)
    else $error("code shown during emergency stop");
  a_push_code_off: assert property ( // R12
    st.blocked && !emg_act && !st.teach && st.last_push
    |=> o_cpl_code == 4'h0)
    else $error("code shown after push move on return");
  // the pin pipeline only holds real pin values three edges after reset
  a_batt_follows: assert property ( // R13 R15
    $past(i_rst_n, 1) && $past(i_rst_n, 2) && $past(i_rst_n, 3) |->
    o_batt_alm_n == (st.abs_var && !$past(i_batt_low, 3)))
    else $error("battery output wrong");
  a_emg_follows: assert property ( // R17
    $past(i_rst_n, 1) && $past(i_rst_n, 2) && $past(i_rst_n, 3) |->
    o_emg_n == $past(i_emg_n, 3))
    else $error("stop status does not follow the pin");
  a_servo_follows: assert property ( // R19
    $past(i_rst_n, 1) && $past(i_rst_n, 2) && $past(i_rst_n, 3) |->
    o_servo_en == $past(i_servo_on, 3))
    else $error("servo enable does not follow the pin");
  a_empty_no_move: assert property ( // R22
    st.seq == PPH_IDLE && rise_start && !alarm_any && o_servo_en &&
    !emg_act && !st.entry_ok[sel] |=> st.alm_empty && !o_move_req)
    else $error("empty entry started a move");
  a_discard_pause: assert property (o_discard |-> // R20
    $past(st.seq) == PPH_MOVE && $past(paused))
    else $error("travel discarded outside a pause");

  c_home_then_move: cover property (o_home_req ##[1:200] o_move_req);
  c_move_done: cover property ($rose(o_pos_cpl) && o_cpl_code != 4'h0);
  c_discard: cover property (o_discard);
  c_empty_alarm: cover property ($rose(st.alm_empty));

endmodule : pph_top
`default_nettype wire

// ===== include/pph_pkg.sv
// shared types and constants for the positioner parallel i/o handshake
// assumes one 100 mhz clock and an axi4-lite master with 32-bit data
package pph_pkg;
  // clock and long-interval timing
  localparam int unsigned PPH_CLK_PERIOD_NS = 10;
  localparam longint unsigned PPH_BATT_ERR_HOURS = 220;
  localparam longint unsigned PPH_NS_PER_HOUR = 64'd3600000000000;
  localparam longint unsigned PPH_BATT_ERR_CYCLES =
    PPH_BATT_ERR_HOURS * PPH_NS_PER_HOUR / PPH_CLK_PERIOD_NS;
  localparam int PPH_CNT_W = 64;

  // bit positions in the raw pin vector
  localparam int PPH_PIN_SERVO = 0;
  localparam int PPH_PIN_PAUSE_N = 1;
  localparam int PPH_PIN_RESET = 2;
  localparam int PPH_PIN_START = 3;
  localparam int PPH_PIN_SEL_LO = 4;
  localparam int PPH_PIN_EMG_N = 8;
  localparam int PPH_PIN_BATT = 9;
  localparam int PPH_PIN_W = 10;

  // register byte offsets and fields
  localparam logic [3:0] PPH_OFF_CTRL = 4'h0;
  localparam logic [3:0] PPH_OFF_ZONE = 4'h4;
  localparam logic [3:0] PPH_OFF_TABLE = 4'h8;
  localparam logic [3:0] PPH_OFF_STATUS = 4'hc;
  localparam int PPH_CTRL_TEACH = 0;
  localparam int PPH_CTRL_ABS_RST = 1;
  localparam logic [1:0] PPH_RESP_OKAY = 2'h0;
  localparam logic [1:0] PPH_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PPH_IDLE = 2'b00,
    PPH_HOME = 2'b01,
    PPH_MOVE = 2'b10
  } pph_seq_e;

  typedef struct packed {
    logic awvalid; logic [31:0] awaddr; logic wvalid; logic [31:0] wdata;
    logic [3:0] wstrb; logic bready; logic arvalid; logic [31:0] araddr;
    logic rready;
  } pph_axi_req_s;

  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } pph_axi_rsp_s;

  typedef struct packed {
    logic [PPH_PIN_W-1:0] s1, s2, s3;
    pph_axi_rsp_s axi;
    logic aw_ok, w_ok; logic [3:0] waddr; logic [31:0] wdata;
    logic [3:0] wstrb;
    logic teach, abs_var, booted;
    logic [15:0] zone_lo, zone_hi, entry_ok, push;
    pph_seq_e seq;
    logic [3:0] tgt, last_tgt; logic last_push, blocked;
    logic alm_empty, alm_fault, alm_oc, batt_err;
    logic [PPH_CNT_W-1:0] batt_cnt;
    logic servo_en, halt, discard, move_req, home_req, abs_rst;
    logic alarm_n, zone, home_cpl, pos_cpl; logic [3:0] code;
    logic batt_n, moving, emg_n;
  } pph_state_s;
endpackage : pph_pkg

// ===== verification/pph_motion_model.sv
// motion core stand-in: finishes each homing or move after a delay
// assumes one-cycle request pulses on the shared system clock
`timescale 1ns/100ps
`default_nettype none
module pph_motion_model (
  input wire logic i_clk,
  input wire logic i_home_req,
  input wire logic i_move_req,
  input wire logic i_halt,
  input wire logic i_discard,
  input wire logic [7:0] i_delay,
  output logic o_home_done,
  output logic o_move_done,
  output logic o_moving
);
  logic [7:0] left = '0;
  logic hm = 1'b0;
  initial {o_home_done, o_move_done} = 2'b00;
  // travel waits at rest while halted, dropped on discard
  always @(posedge i_clk)
  begin
    o_home_done <= 0;
    o_move_done <= 0;
    if (i_discard)
      left <= 8'h0;
    else if (i_home_req || i_move_req)
    begin
      left <= i_delay;
      hm <= i_home_req;
    end
    else if (left == 8'h1 && !i_halt)
    begin
      left <= 8'h0;
      o_home_done <= hm;
      o_move_done <= !hm;
    end
    else if (left != 8'h0 && !i_halt)
      left <= left - 8'h1;
  end
  // at rest whenever halted, so stop timing is zero cycles
  always_comb o_moving = left != 0 && !i_halt;
endmodule : pph_motion_model
`default_nettype wire

// ===== verification/positioner_parallel_io_handshake_test.sv
// self-checking bench for the positioner discrete handshake block
// assumes pph_pkg and the motion stand-in are compiled before it
`timescale 1ns/100ps
`default_nettype none
module positioner_parallel_io_handshake_test;
  import pph_pkg::*;
  logic clk = 0, rst_n = 0, servo = 1, pause_n = 1, rst_pin = 0;
  logic start = 0, emg_n = 1, batt = 0, absv = 0, fault = 0, oc = 0;
  logic band = 1;
  logic [3:0] sel = 0;
  logic [15:0] pos = 0;
  logic [7:0] dly = 8'h04;
  pph_axi_req_s req = '0;
  pph_axi_rsp_s rsp;
  logic sv_en, halt, disc, mreq, hreq, alarm_n, zone, hcpl, pcpl;
  logic batt_n, berr, moving, emg_o, hdone, mdone, mmov, pp = 0;
  logic ars, av = 0;
  int na = 0;
  logic [3:0] idx, code;
  int n_errors = 0, n_tests = 0, cyc = 0, nh = 0, nm = 0, nd = 0;
  logic [33:0] expq[$];

  // 100 mhz system clock
  always #5 clk = ~clk;

  pph_top #(.BATT_ERR_CYCLES(20)) dut (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_clk_en(1'b1),
    .i_servo_on(servo), .i_pause_n(pause_n), .i_reset(rst_pin),
    .i_start(start), .i_sel(sel), .i_emg_n(emg_n), .i_batt_low(batt),
    .i_abs_variant(absv), .i_abs_valid(av), .i_fault(fault),
    .i_overcurrent(oc), .i_home_done(hdone), .i_move_done(mdone),
    .i_mot_moving(mmov), .i_in_band(band), .i_act_pos(pos),
    .i_axi(req), .o_axi(rsp), .o_servo_en(sv_en), .o_halt(halt),
    .o_discard(disc), .o_move_req(mreq), .o_home_req(hreq),
    .o_move_idx(idx), .o_abs_rst(ars), .o_alarm_n(alarm_n),
    .o_zone(zone), .o_home_cpl(hcpl), .o_pos_cpl(pcpl),
    .o_cpl_code(code), .o_batt_alm_n(batt_n), .o_batt_err(berr),
    .o_moving(moving), .o_emg_n(emg_o)
  );

  pph_motion_model motion (
    .i_clk(clk), .i_home_req(hreq), .i_move_req(mreq), .i_halt(halt),
    .i_discard(disc), .i_delay(dly), .o_home_done(hdone),
    .o_move_done(mdone), .o_moving(mmov)
  );

  task automatic chk(string nam, logic [33:0] got, logic [33:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s exp %h seen %h", nam, exp, got);
    end
  endtask : chk

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  // pulse tallies; codes must drop with position-complete
  always @(posedge clk)
  begin
    if (pp === 1'b1 && pcpl === 1'b0) chk("code_drop", code, 0);
    pp <= pcpl;
    if (hreq === 1'b1) nh++;
    if (mreq === 1'b1) nm++;
    if (disc === 1'b1) nd++;
    if (ars === 1'b1) na++;
  end

  // each axi answer taken against the oldest note
  always @(posedge clk)
  begin
    if (rsp.bvalid && req.bready)
      chk("bresp", {rsp.bresp, 32'h0}, expq.pop_front());
    if (rsp.rvalid && req.rready)
      chk("rdata", {rsp.rresp, rsp.rdata}, expq.pop_front());
  end

  // hang guard, several times the expected run
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      n_errors++;
      results();
    end
  end

  // waits for the answer however long; only the hang guard ends it
  task automatic wr(logic [31:0] a, logic [31:0] d, logic [1:0] e);
    expq.push_back({e, 32'h0});
    @(posedge clk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1;
    req.wvalid <= 1;
    req.bready <= 1;
    do
    begin
      @(posedge clk);
      if (rsp.awready) req.awvalid <= 0;
      if (rsp.wready) req.wvalid <= 0;
    end
    while (!rsp.bvalid);
    req.bready <= 0;
  endtask : wr

  task automatic rd(logic [31:0] a, logic [33:0] e);
    expq.push_back(e);
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1;
    req.rready <= 1;
    do
    begin
      @(posedge clk);
      if (rsp.arready) req.arvalid <= 0;
    end
    while (!rsp.rvalid);
    req.rready <= 0;
  endtask : rd

  // pin held past the synchroniser, then released as long
  task automatic kick(bit r);
    @(posedge clk);
    if (r) rst_pin <= 1;
    else start <= 1;
    repeat (5) @(posedge clk);
    rst_pin <= 0;
    start <= 0;
    repeat (5) @(posedge clk);
  endtask : kick

  task automatic mv(logic [3:0] s, int h);
    int t = 0, h0 = nh, m0 = nm;
    @(posedge clk);
    sel <= s;
    kick(0);
    while (!(nm > m0 && pcpl === 1'b1) && t < 300)
    begin
      @(posedge clk);
      t++;
    end
    chk("mv_wait", t < 300, 1);
    chk("idx", idx, s);
    chk("code", code, s);
    chk("homing", nh - h0, h);
    chk("home_cpl", hcpl, 1);
  endtask : mv

  initial
  begin
    int s, p, d0, m0;
    int zp[4] = '{99, 100, 200, 201};
    void'($urandom(32'hdaab));
    repeat (2) @(posedge clk);
    rst_n <= 1;
    repeat (5) @(posedge clk);
    chk("pos_cpl", pcpl, 1);
    chk("alarm_n", alarm_n, 1);
    chk("emg_n", emg_o, 1);
    chk("batt_n", batt_n, 0);
    chk("servo_en", sv_en, 1);
    wr(32'hc, 32'hffff_ffff, 0);
    rd(32'hc, 0);
    rd(32'h11, {2'h2, 32'h0});
    wr(32'h40, 32'h1, 2'h2);
    wr(32'h8, 32'h0002_7fff, 0);
    rd(32'h8, 34'h0_0002_7fff);
    wr(32'h4, {16'd200, 16'd100}, 0);
    for (int i = 0; i < 8; i++)
    begin
      p = (i < 4) ? zp[i] : $urandom % 400;
      pos <= p[15:0];
      repeat (4) @(posedge clk);
      chk("zone", zone, p >= 100 && p <= 200);
    end
    $display("test registers and zone done");
    mv(0, 1);
    repeat (3)
    begin
      s = 2 + $urandom % 13;
      mv(s[3:0], 0);
    end
    emg_n <= 0;
    repeat (6) @(posedge clk);
    chk("emg_n", emg_o, 0);
    chk("code", code, 0);
    chk("home_cpl", hcpl, 1);
    emg_n <= 1;
    repeat (6) @(posedge clk);
    chk("emg_n", emg_o, 1);
    chk("code", code, s);
    wr(0, 1, 0);
    band <= 0;
    repeat (3) @(posedge clk);
    chk("code", code, 0);
    wr(0, 0, 0);
    repeat (3) @(posedge clk);
    chk("code", code, 0);
    band <= 1;
    mv(1, 0);
    emg_n <= 0;
    repeat (6) @(posedge clk);
    emg_n <= 1;
    repeat (6) @(posedge clk);
    chk("code", code, 0);
    $display("test motion done");
    m0 = nm;
    sel <= 15;
    kick(0);
    chk("alarm_n", alarm_n, 0);
    kick(1);
    chk("alarm_n", alarm_n, 1);
    fault <= 1;
    kick(1);
    chk("alarm_n", alarm_n, 0);
    fault <= 0;
    kick(1);
    chk("alarm_n", alarm_n, 1);
    servo <= 0;
    sel <= 2;
    kick(0);
    chk("servo_en", sv_en, 0);
    chk("moves", nm - m0, 0);
    servo <= 1;
    dly <= 60;
    repeat (5) @(posedge clk);
    chk("servo_en", sv_en, 1);
    kick(0);
    chk("moving", moving, 1);
    pause_n <= 0;
    repeat (5) @(posedge clk);
    chk("halt", halt, 1);
    chk("moving", moving, 0);
    d0 = nd;
    kick(1);
    chk("discard", nd - d0, 1);
    chk("pos_cpl", pcpl, 0);
    pause_n <= 1;
    dly <= 4;
    repeat (5) @(posedge clk);
    chk("moving", moving, 0);
    mv(3, 0);
    oc <= 1;
    repeat (3) @(posedge clk);
    oc <= 0;
    kick(1);
    chk("alarm_n", alarm_n, 0);
    $display("test alarms done");
    rst_n <= 0;
    absv <= 1;
    batt <= 1;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    repeat (6) @(posedge clk);
    chk("batt_n", batt_n, 0);
    chk("batt_err", berr, 0);
    chk("home_cpl", hcpl, 0);
    repeat (25) @(posedge clk);
    chk("batt_err", berr, 1);
    wr(0, 2, 0);
    repeat (2) @(posedge clk);
    chk("home_cpl", hcpl, 1);
    chk("abs_rst", na, 1);
    fault <= 1;
    repeat (5) @(posedge clk);
    chk("home_cpl", hcpl, 0);
    // power-up with valid absolute data comes up homed
    fault <= 0;
    av <= 1;
    rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    chk("home_cpl", hcpl, 1);
    $display("test absolute variant done");
    results();
  end
endmodule : positioner_parallel_io_handshake_test
`default_nettype wire
